// ===== logic/spime_top.v
// spi master engine for one port group, registers as plain ports
// Operation
// - config is loaded first; each data write while idle starts a transfer with it
// - read data is offered only when the capture flag was set
// - float flag puts every driven spi pin into high impedance
// - end flag makes the next transfer the last; chip select then drops
// - capture flag delivers shifted-in bits as an event after transfer
// - chip-select polarity flag sets the asserted level of selects
// - clock polarity flag sets the idle level of the serial clock
// - phase set: sample on trailing edge, change on leading; clear: swapped
// - lsb-first flag sends bit zero first, otherwise msb first
// - three-wire flag uses one shared data line for both directions
// - serial clock is the core clock divided by 2 through 257
// - msb-first shifting starts from bit 31 of the data word
// - config holds length in bits, divisor and one select bit per slave
// - port acts as spi master only in its spi build variant
`include "spime_defs.vh"
module spime_top #(
    parameter          SPI_VARIANT = 1,
    parameter integer  NUM_CS      = 3
) (
    input  wire              CLK,
    input  wire              RST,
    input  wire              CFG_WRITE,
    input  wire [7:0]        CFG_FLAGS,
    input  wire [5:0]        CFG_LENGTH,
    input  wire [8:0]        CFG_DIV,
    input  wire [NUM_CS-1:0] CFG_CS,
    input  wire              DATA_WRITE,
    input  wire [31:0]       DATA_IN,
    output wire              DATA_READY,
    output reg               RX_VALID,
    output reg  [31:0]       RX_DATA,
    output wire              BUSY,
    output wire              SCK_O,
    output wire              SCK_OE,
    output wire [NUM_CS-1:0] CS_O,
    output wire [NUM_CS-1:0] CS_OE,
    output wire              MOSI_O,
    output wire              MOSI_OE,
    input  wire              MOSI_I,
    input  wire              MISO_I,
    input  wire [7:0]        DIO_O,
    input  wire [7:0]        DIO_OE,
    output wire [7:0]        PIN_O,
    output wire [7:0]        PIN_OE
);
    // ********************************
    // configuration and state
    // ********************************
    reg [7:0]        flags;
    reg [5:0]        length;
    reg [8:0]        div;
    reg [NUM_CS-1:0] cs_mask;
    reg [1:0]        state;
    reg [31:0]       shreg;
    reg [5:0]        bits_left;
    reg [8:0]        cnt;
    reg              sck;
    reg              cs_active;
    reg              last_flag;
    reg              capture;
    reg              mosi_s1;
    reg              mosi_s2;
    reg              miso_s1;
    reg              miso_s2;
    reg              out_q;
    reg [31:0]       rx_sh;
    reg [1:0]        samp_p;
    wire             lsb = flags[`SPIME_FLAG_LSB_FIRST];
    wire             half = flags[`SPIME_FLAG_HALF_DPX];
    wire             cpha = flags[`SPIME_FLAG_CLK_PHASE];
    wire             cpol = flags[`SPIME_FLAG_CLK_POL];
    wire             din = half ? mosi_s2 : miso_s2;
    wire [8:0]       half_lo = {1'b0, div[8:1]};
    wire [8:0]       half_hi = div - half_lo;
    wire             tick = (cnt == 9'h001);
    // first half-period: ends with sample when phase clear
    wire             lead_sample = ~cpha;
    wire             sample_now = tick && (lead_sample
                         ? (state == `SPIME_ST_LEAD)
                         : (state == `SPIME_ST_TRAIL));

    assign BUSY = (state != `SPIME_ST_IDLE);
    assign DATA_READY = ~BUSY;

    function [8:0] clamp_div;
        input [8:0] d;
        begin
            if (d < `SPIME_DIV_MIN)
                clamp_div = `SPIME_DIV_MIN;
            else if (d > `SPIME_DIV_MAX)
                clamp_div = `SPIME_DIV_MAX;
            else
                clamp_div = d;
        end
    endfunction

    function [31:0] shift_in;
        input [31:0] s;
        input        b;
        input        l;
        begin
            shift_in = l ? {b, s[31:1]} : {s[30:0], b};
        end
    endfunction

    function head_of;
        input [31:0] s;
        input        l;
        begin
            head_of = l ? s[0] : s[31];
        end
    endfunction

    // ********************************
    // input synchronisers
    // ********************************
    always @(posedge CLK)
    begin
        mosi_s1 <= MOSI_I;
        mosi_s2 <= mosi_s1;
        miso_s1 <= MISO_I;
        miso_s2 <= miso_s1;
    end

    // ********************************
    // transfer engine
    // ********************************
    always @(posedge CLK)
    begin
        if (RST)
        begin
            flags     <= `SPIME_FLAGS_RESET;
            length    <= `SPIME_LEN_RESET;
            div       <= `SPIME_DIV_RESET;
            cs_mask   <= {NUM_CS{1'b0}};
            state     <= `SPIME_ST_IDLE;
            shreg     <= 32'h0000_0000;
            bits_left <= 6'h00;
            cnt       <= 9'h000;
            sck       <= 1'b0;
            cs_active <= 1'b0;
            last_flag <= 1'b0;
            capture   <= 1'b0;
            RX_VALID  <= 1'b0;
            RX_DATA   <= 32'h0000_0000;
            out_q     <= 1'b0;
            rx_sh     <= 32'h0000_0000;
            samp_p    <= 2'h0;
        end
        else
        begin
            RX_VALID <= 1'b0;
            samp_p   <= {samp_p[0], sample_now};
            // the synchroniser holds each slave bit back two clocks
            if (samp_p[1])
                rx_sh <= shift_in(rx_sh, din, lsb);
            if (CFG_WRITE && !BUSY)
            begin
                flags   <= CFG_FLAGS;
                length  <= (CFG_LENGTH == 6'h00) ? 6'h20 : CFG_LENGTH;
                div     <= clamp_div(CFG_DIV);
                cs_mask <= CFG_CS;
            end
            case (state)
            `SPIME_ST_IDLE:
            begin
                sck <= cpol;
                if (DATA_WRITE && SPI_VARIANT != 0)
                begin
                    shreg     <= DATA_IN;
                    out_q     <= head_of(DATA_IN, lsb);
                    rx_sh     <= 32'h0000_0000;
                    bits_left <= length;
                    last_flag <= flags[`SPIME_FLAG_END];
                    capture   <= flags[`SPIME_FLAG_INPUT];
                    cs_active <= 1'b1;
                    cnt       <= half_hi;
                    state     <= `SPIME_ST_LEAD;
                end
            end
            `SPIME_ST_LEAD:
            begin
                if (tick)
                begin
                    sck   <= ~cpol;
                    cnt   <= half_lo;
                    state <= `SPIME_ST_TRAIL;
                    if (lead_sample)
                        shreg <= shift_in(shreg, 1'b0, lsb);
                    else
                        out_q <= head_of(shreg, lsb);
                end
                else
                    cnt <= cnt - 9'h001;
            end
            `SPIME_ST_TRAIL:
            begin
                if (tick)
                begin
                    sck <= cpol;
                    if (lead_sample)
                        out_q <= head_of(shreg, lsb);
                    else
                        shreg <= shift_in(shreg, 1'b0, lsb);
                    if (bits_left == 6'h01)
                    begin
                        cnt   <= `SPIME_SYNC_TAIL;
                        state <= `SPIME_ST_TAIL;
                    end
                    else
                    begin
                        bits_left <= bits_left - 6'h01;
                        cnt       <= half_hi;
                        state     <= `SPIME_ST_LEAD;
                    end
                end
                else
                    cnt <= cnt - 9'h001;
            end
            // select and idle clock hold until the last bit is through
            `SPIME_ST_TAIL:
            begin
                if (tick)
                begin
                    state <= `SPIME_ST_IDLE;
                    if (last_flag)
                        cs_active <= 1'b0;
                    if (capture)
                    begin
                        RX_VALID <= 1'b1;
                        RX_DATA  <= samp_p[1] ? shift_in(rx_sh, din, lsb)
                            : rx_sh;
                    end
                end
                else
                    cnt <= cnt - 9'h001;
            end
            default:
                state <= `SPIME_ST_IDLE;
            endcase
        end
    end

    // ********************************
    // pin drive
    // ********************************
    // output bit moves on the change edge and when a transfer loads, never where the slave samples
    wire   out_bit = out_q;
    wire   drive   = (SPI_VARIANT != 0) && !flags[`SPIME_FLAG_FLOAT];
    wire   cs_lvl  = flags[`SPIME_FLAG_CS_POL];
    wire   rx_phase = half && capture && BUSY;
    assign SCK_O   = sck;
    assign SCK_OE  = drive;
    assign CS_O    = (cs_active ? cs_mask : {NUM_CS{1'b0}})
                     ^ {NUM_CS{~cs_lvl}};
    assign CS_OE   = {NUM_CS{drive}};
    assign MOSI_O  = out_bit;
    // three-wire capture releases the shared line for the slave
    assign MOSI_OE = drive && !rx_phase;
    assign PIN_O   = (SPI_VARIANT != 0) ? 8'h00 : DIO_O;
    assign PIN_OE  = (SPI_VARIANT != 0) ? 8'h00 : DIO_OE;
endmodule

// ===== include/spime_defs.vh
// constants for the spi master engine
`ifndef SPIME_DEFS_VH
`define SPIME_DEFS_VH
`define SPIME_FLAG_FLOAT      0
`define SPIME_FLAG_END        1
`define SPIME_FLAG_INPUT      2
`define SPIME_FLAG_CS_POL     3
`define SPIME_FLAG_CLK_POL    4
`define SPIME_FLAG_CLK_PHASE  5
`define SPIME_FLAG_LSB_FIRST  6
`define SPIME_FLAG_HALF_DPX   7
`define SPIME_FLAGS_RESET     8'h00
`define SPIME_DIV_MIN         9'h002
`define SPIME_DIV_MAX         9'h101
`define SPIME_DIV_RESET       9'h002
`define SPIME_LEN_RESET       6'h08
`define SPIME_ST_IDLE         2'h0
`define SPIME_ST_LEAD         2'h1
`define SPIME_ST_TRAIL        2'h2
`define SPIME_ST_TAIL         2'h3
// input synchroniser depth: the last sampled bit needs this many clocks
`define SPIME_SYNC_TAIL       9'h002
`endif

// ===== bench/spime_slave.sv
// spi slave partner: inverting loop-back, records what it samples
module spime_slave (
    input  wire        clk, sel, sck, mosi, pol, pha,
    output wire        miso,
    output reg  [31:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    reg ps = 1'b0;
    reg pm = 1'b0;
    reg tg = 1'b0;
    // deselected line toggles so a stale level never looks valid
    assign miso = sel ? ~mosi : tg;
    always @(posedge clk)
    begin
        ps <= sck;
        pm <= mosi;
        tg <= ~tg;
        if (sel && sck != ps && ((sck != pol) ^ pha))
            got <= {got[30:0], pm};
    end
endmodule

// ===== bench/spime_checker.sv
// assertions on the ports of the spi master engine
`include "spime_defs.vh"
module spime_checker #(parameter integer NUM_CS = 3) (
    input wire              CLK, RST, CFG_WRITE, DATA_WRITE, DATA_READY,
    input wire              RX_VALID, BUSY, SCK_O, SCK_OE, MOSI_OE, MOSI_O,
    input wire [7:0]        CFG_FLAGS, PIN_OE, PIN_O,
    input wire [5:0]        CFG_LENGTH,
    input wire [8:0]        CFG_DIV,
    input wire [NUM_CS-1:0] CFG_CS, CS_O, CS_OE
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    reg [7:0] f, uf;
    reg [NUM_CS-1:0] m, um;
    reg [14:0] e, n;
    reg [5:0] l;
    reg [8:0] d;
    wire go = DATA_WRITE && DATA_READY;
    // uf/um: the config a transfer really uses, frozen at its start
    always @(posedge CLK)
    begin
        if (RST)
            f <= 8'h00;
        else if (CFG_WRITE && !BUSY)
            {f, m, l, d} <= {CFG_FLAGS, CFG_CS, CFG_LENGTH, CFG_DIV};
        if (go)
            {uf, um, n} <= {f, m, 15'h0000};
        else if (BUSY)
            n <= n + 15'h0001;
        if (go)
            // a fixed tail lets the last sampled bit clear the synchroniser
            e <= {9'h000, l == 6'h00 ? 6'h20 : l} * {6'h00, d}
                + {6'h00, `SPIME_SYNC_TAIL};
    end
    a_float_hiz: assert property (f[0] && $past(f[0]) |->
        !SCK_OE && !MOSI_OE && CS_OE == '0) else $error("pins driven");
    a_clk_idle: assert property (
        !BUSY && !$past(BUSY) && $stable(f) && !f[0] |-> SCK_O == f[4])
        else $error("sck idle level");
    a_start_busy: assert property (go |=> BUSY [*2])
        else $error("transfer not started");
    a_bit_count: assert property ($fell(BUSY) |-> n == e)
        else $error("transfer length");
    a_cs_active: assert property (BUSY && !uf[0] |->
        CS_O == (uf[3] ? um : ~um)) else $error("select level");
    a_cs_release: assert property (
        $fell(BUSY) && !uf[0] |-> ##1 (BUSY ||
        CS_O == (uf[1] ? {NUM_CS{~uf[3]}} : uf[3] ? um : ~um)))
        else $error("select after transfer");
    a_rx_when: assert property ($fell(BUSY) |-> RX_VALID == uf[2])
        else $error("capture event");
    a_rx_at_end: assert property (RX_VALID |-> $fell(BUSY))
        else $error("event timing");
    a_three_wire: assert property (
        BUSY && uf[7] && uf[2] |-> !MOSI_OE) else $error("shared line driven");
    a_mosi_edge: assert property (
        BUSY && $past(BUSY) && $changed(MOSI_O) |->
        $changed(SCK_O) && ((SCK_O != uf[4]) == uf[5]))
        else $error("data moved off its edge");
    a_pins_spi: assert property (PIN_OE == 8'h00 && PIN_O == 8'h00)
        else $error("plain pins driven");
endmodule

bind spime_top spime_checker #(.NUM_CS(NUM_CS)) chk_u (.CLK(CLK), .RST(RST),
    .CFG_WRITE(CFG_WRITE), .CFG_FLAGS(CFG_FLAGS), .CFG_LENGTH(CFG_LENGTH),
    .CFG_DIV(CFG_DIV), .CFG_CS(CFG_CS), .DATA_WRITE(DATA_WRITE),
    .DATA_READY(DATA_READY), .RX_VALID(RX_VALID), .BUSY(BUSY),
    .SCK_O(SCK_O), .SCK_OE(SCK_OE), .CS_O(CS_O), .CS_OE(CS_OE),
    .MOSI_OE(MOSI_OE), .MOSI_O(MOSI_O), .PIN_OE(PIN_OE), .PIN_O(PIN_O));

// ===== bench/testbench.sv
// self-checking bench for the spi master engine
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: %h %h", $time, (a), (b)); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk = 0, rst = 1, cw = 0, dw = 0;
    reg [7:0] fl = 8'h00, dio = 8'h00;
    reg [5:0] ln = 6'h08;
    reg [8:0] dv = 9'h002;
    reg [2:0] cs = 3'h1;
    reg [31:0] din = 32'h0000_0000, lf = 32'h0001_3C60;
    wire rdy, rxv, busy, sck, mo, mooe, miso;
    wire [31:0] rxd, got;
    wire [2:0] cso;
    int errors = 0, tests_run = 0;
    always #4 clk = ~clk;
    spime_top #(.SPI_VARIANT(1), .NUM_CS(3)) dut_u (.CLK(clk), .RST(rst),
        .CFG_WRITE(cw), .CFG_FLAGS(fl), .CFG_LENGTH(ln), .CFG_DIV(dv),
        .CFG_CS(cs), .DATA_WRITE(dw), .DATA_IN(din), .DATA_READY(rdy),
        .RX_VALID(rxv), .RX_DATA(rxd), .BUSY(busy), .SCK_O(sck), .SCK_OE(),
        .CS_O(cso), .CS_OE(), .MOSI_O(mo), .MOSI_OE(mooe),
        .MOSI_I(mooe ? mo : miso), .MISO_I(miso), .DIO_O(dio),
        .DIO_OE(~dio), .PIN_O(), .PIN_OE());
    spime_slave slave_u (.clk(clk), .sel(cso[0] == fl[3]), .sck(sck),
        .mosi(mo), .pol(fl[4]), .pha(fl[5]), .miso(miso), .got(got));
    function [31:0] nx(input [31:0] s);
        nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task results;
    begin
        if (errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task xfer(input [7:0] f, input [5:0] l, input [8:0] d, input [31:0] x);
        int k, n;
        reg [31:0] m, w, r;
    begin
        n = l == 0 ? 32 : l;
        m = 32'hFFFF_FFFF >> (32 - n);
        w = x >> (32 - n);
        if (f[6])
            for (k = 0; k < n; k++) w[n - 1 - k] = x[k];
        @(posedge clk);
        {fl, ln, dv, cs, cw, dio} <= {f, l, d, x[2:0] | 3'h1, 1'b1, x[15:8]};
        @(posedge clk);
        {cw, din, dw} <= {1'b0, x, 1'b1};
        @(posedge clk);
        // write held into the busy phase must be ignored
        din <= ~x;
        @(posedge clk);
        dw <= 0;
        k = 0;
        do @(negedge clk);
        while (!(f[2] ? rxv === 1'b1 : busy === 1'b0) && ++k < 9000);
        if (k >= 9000) errors++;
        r = f[6] ? rxd >> (32 - n) : rxd;
        if (!f[0] && !(f[7] && f[2])) `CHK(got & m, w & m)
        if (f[2]) `CHK(r & m, ~(f[6] ? x : w) & m)
    end
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 0;
        for (int i = 0; i < 16; i++)
        begin
            lf = nx(lf);
            xfer({1'b0, i[2:0], i[3], 3'b110}, {1'b0, lf[4:0]},
                {6'h00, lf[7:5]} + 9'h004, lf);
        end
        xfer(8'h04, 6'h08, 9'h005, 32'h5A5A_A5A5);
        xfer(8'h06, 6'h20, 9'h005, 32'h0F0F_F0F5);
        xfer(8'h02, 6'h01, 9'h002, lf);
        xfer(8'h02, 6'h01, 9'h101, lf);
        xfer(8'h86, 6'h08, 9'h006, lf);
        xfer(8'h03, 6'h08, 9'h004, lf);
        results;
    end
    initial
    begin
        #400000;
        errors++;
        results;
    end
endmodule
